// ### sim/link_receiver_model.sv
// behavioural link receiver driving the sync request pin
`timescale 1ns/1ps
`include "framer_defines.svh"

// ==========================================
// receiver model
module link_receiver_model
   import framer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench control
   input wire logic forceSync,
   input wire logic invertPol,
   // link
   input wire lane_word_t laneIn,
   output logic syncPin
);
   logic [2:0] seen_r;
   logic requesting;
   // request held until four sync characters in a row
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seen_r <= 3'h0;
      end else if (forceSync) begin
         seen_r <= 3'h0;
      end else if (seen_r != 3'h4) begin
         seen_r <= (laneIn.valid && laneIn.ctrl && laneIn.data == `CHAR_SYNC) ?
            seen_r + 3'h1 : 3'h0;
      end
   end
   assign requesting = (seen_r != 3'h4);
   assign syncPin = invertPol ? requesting : !requesting;
endmodule

// ### sim/serial_link_framer_config_chk.sv
// port-level assertions for the framer
`timescale 1ns/1ps
`include "framer_defines.svh"

// ==========================================
// checker
module serial_link_framer_config_chk
   import framer_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // sample stream
   input wire logic sampleValid,
   input wire logic sampleReady,
   input wire sample_pair_t sampleIn,
   // link pins
   input wire logic linkSyncRequestIn,
   input wire lane_word_t laneOut0,
   input wire lane_word_t laneOut1,
   input wire logic [1:0] lanePhyPowerDown
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic wrDone;
   logic queueOn_r;
   logic [1:0] offCnt_r;
   assign wrDone = write && !waitrequest;

   // ==========================================
   // queue enable shadow and idle count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         queueOn_r <= 1'b0;
      end else if (wrDone && address[11:2] == `IDX_QUEUE_START) begin
         queueOn_r <= writedata[0];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         offCnt_r <= 2'h0;
      end else if (queueOn_r) begin
         offCnt_r <= 2'h0;
      end else if (offCnt_r != 2'h3) begin
         offCnt_r <= offCnt_r + 2'h1;
      end
   end

   // ==========================================
   // assertions
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   a_wait_idle: assert property (!(read || write) |-> waitrequest)
      else $error("waitrequest low without a request");
   a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_pd_follow: assert property (wrDone && address[11:2] == `IDX_POWER_DELAY
      |-> ##2 lanePhyPowerDown == $past(writedata[1:0], 2))
      else $error("power-down pins do not follow write");
   a_pd_lane0: assert property (lanePhyPowerDown[0] && $past(lanePhyPowerDown[0])
      |-> laneOut0 == 18'h00000)
      else $error("lane 0 active while powered down");
   a_pd_lane1: assert property (lanePhyPowerDown[1] && $past(lanePhyPowerDown[1])
      |-> laneOut1 == 18'h00000)
      else $error("lane 1 active while powered down");
   a_queue_off: assert property (offCnt_r == 2'h3 |-> !laneOut0.valid && !laneOut1.valid)
      else $error("lane payload while queue disabled");
   a_ctrl_chars: assert property (laneOut0.valid && laneOut0.ctrl
      |-> laneOut0.data inside {`CHAR_SYNC, `CHAR_MF_START, `CHAR_ALIGN})
      else $error("unknown control character on lane 0");
endmodule

bind serial_link_framer_config serial_link_framer_config_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
   .clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .sampleValid,
   .sampleReady, .sampleIn, .linkSyncRequestIn, .laneOut0, .laneOut1, .lanePhyPowerDown);

// ### sim/serial_link_framer_config_tb.sv
// self-checking bench for the framer
`timescale 1ns/1ps
`include "framer_defines.svh"
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failCount++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

// ==========================================
// bench
module serial_link_framer_config_tb
   import framer_pkg::*;
;
   localparam int DEPTH = 16;
   localparam int KF = 3;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] address = 12'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic sampleValid = 1'b0;
   logic sampleReady;
   sample_pair_t sampleIn = '0;
   logic linkSyncRequestIn;
   lane_word_t laneOut0;
   lane_word_t laneOut1;
   logic [1:0] lanePhyPowerDown;
   logic forceSync = 1'b0;
   logic invertPol = 1'b0;
   logic inAlign = 1'b0;
   logic relPrev = 1'b0;
   int failCount = 0;
   int testsRun = 0;
   int cyc = 0;
   int mfCnt = 0;
   int alnCnt = 0;
   int relAt = 0;
   int n;
   int mfAt[2];
   logic [15:0] got0[$];
   logic [15:0] got1[$];
   logic [31:0] rd;
   logic [7:0] pv;
   logic [15:0] c0;
   logic [15:0] c1;
   sample_pair_t s;
   logic [9:0] ri[14] = '{`IDX_FRAMES_PER_MF, `IDX_CONV_COUNT, `IDX_SAMPLES_PER_FRAME,
      `IDX_RESERVED_ONE, `IDX_RESERVED_TWO, `IDX_LANE0_ID, `IDX_LANE1_ID, `IDX_LANE0_CHECKSUM,
      `IDX_LANE1_CHECKSUM, `IDX_QUEUE_START, `IDX_SWAP, `IDX_POWER_DELAY, `IDX_IF_CONTROL0,
      10'h1C7};
   logic [7:0] rv[14] = '{8'h1F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h44, 8'h45,
      8'h00, 8'h00, 8'h00, 8'h14, 8'h00};

   always #4 clk = ~clk;

   serial_link_framer_config #(.FIFO_DEPTH(DEPTH)) dut (.clk, .rst, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .sampleValid, .sampleReady, .sampleIn,
      .linkSyncRequestIn, .laneOut0, .laneOut1, .lanePhyPowerDown);
   link_receiver_model rx (.clk, .rst, .forceSync, .invertPol, .laneIn(laneOut1),
      .syncPin(linkSyncRequestIn));

   // ==========================================
   // lane monitor
   always @(posedge clk) begin
      cyc++;
      if ((linkSyncRequestIn ^ invertPol) && !relPrev) relAt = cyc;
      relPrev = linkSyncRequestIn ^ invertPol;
      if (laneOut1.valid && !laneOut1.ctrl && !inAlign) got1.push_back(laneOut1.data);
      if (laneOut0.valid && laneOut0.ctrl) begin
         inAlign = (laneOut0.data == `CHAR_MF_START);
         if (inAlign && mfCnt < 2) mfAt[mfCnt] = cyc;
         if (inAlign) mfCnt++;
         if (laneOut0.data == `CHAR_ALIGN) alnCnt++;
      end else if (laneOut0.valid && !inAlign) begin
         got0.push_back(laneOut0.data);
      end
   end

   // ==========================================
   // tasks
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
      @(posedge clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= !wr;
      writedata <= {24'h000000, d};
      do @(posedge clk); while (waitrequest);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic chkrd(input logic [9:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      `CHK(rd, {24'h000000, e})
   endtask
   task automatic push(input sample_pair_t v, input int k);
      sampleValid <= 1'b1;
      sampleIn <= v;
      repeat (k) @(posedge clk);
      sampleValid <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic resync(input int k);
      @(posedge clk);
      forceSync <= 1'b1;
      @(posedge clk);
      forceSync <= 1'b0;
      repeat (6) @(posedge clk);
      mfCnt = 0;
      repeat (k) @(posedge clk);
   endtask
   task automatic waitq(input int m);
      repeat (300) begin
         @(posedge clk);
         if (got0.size() >= m && got1.size() >= m) break;
      end
   endtask
   task automatic endt(input string t);
      $display("test %s done", t);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #160000;
      failCount++;
      report_and_stop();
   end

   // ==========================================
   // tests
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 14; k++) begin
         chkrd(ri[k], rv[k]);
      end
      chkrd(`IDX_STATUS, 8'h00);
      endt("reset values");
      for (int k = 0; k < 9; k++) begin
         pv = (k == 2) ? 8'h00 : 8'hA0 + 8'(k);
         bus(1'b1, ri[k], pv);
         chkrd(ri[k], pv);
      end
      bus(1'b1, 10'h1C7, 8'hFF);
      chkrd(10'h1C7, 8'h00);
      bus(1'b1, `IDX_FRAMES_PER_MF, 8'(KF));
      bus(1'b1, `IDX_REPEAT_COUNT, 8'h01);
      endt("readback");
      n = 0;
      sampleValid <= 1'b1;
      sampleIn <= {16'h8000, 16'h1000};
      repeat (24) begin
         @(posedge clk);
         if (sampleReady) begin
            n++;
            sampleIn <= {16'h8000 + 16'(n), 16'h1000 + 16'(n)};
         end
      end
      sampleValid <= 1'b0;
      `CHK(n, DEPTH)
      `CHK(sampleReady, 1'b0)
      `CHK(laneOut0.valid, 1'b0)
      endt("fifo fill");
      mfCnt = 0;
      bus(1'b1, `IDX_QUEUE_START, 8'h01);
      waitq(DEPTH);
      `CHK(mfCnt, 2)
      `CHK(mfAt[1] - mfAt[0], KF + 1)
      `CHK(mfAt[0] - relAt <= KF + 7, 1'b1)
      for (int k = 0; k < DEPTH; k++) begin
         `CHK(got0[k], 16'h1000 + 16'(k))
         `CHK(got1[k], 16'h8000 + 16'(k))
      end
      chkrd(`IDX_STATUS, 8'h04);
      endt("start and drain");
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, `IDX_SWAP, {2'b00, 2'(k), 2'b00, 2'(k)});
         got0.delete();
         got1.delete();
         s = {16'h7700 + 16'(k), 16'h3300 + 16'(k)};
         push(s, 1);
         waitq(1);
         c0 = k[0] ? s.q : s.i;
         c1 = k[1] ? s.i : s.q;
         `CHK(got0[0], k[0] ? c1 : c0)
         `CHK(got1[0], k[1] ? c0 : c1)
      end
      bus(1'b1, `IDX_SWAP, 8'h00);
      endt("swap");
      bus(1'b1, `IDX_POWER_DELAY, 8'h20);
      resync(120);
      `CHK(mfCnt, 2)
      `CHK(mfAt[0] - relAt >= 2 * (KF + 1), 1'b1)
      `CHK(mfAt[0] - relAt <= 3 * (KF + 1) + 10, 1'b1)
      bus(1'b1, `IDX_POWER_DELAY, 8'h00);
      endt("start delay");
      bus(1'b1, `IDX_IF_CONTROL0, 8'h1C);
      resync(80);
      `CHK(mfCnt > 4, 1'b1)
      chkrd(`IDX_STATUS, 8'h03);
      bus(1'b1, `IDX_IF_CONTROL0, 8'h10);
      resync(60);
      `CHK(mfCnt, 0)
      chkrd(`IDX_STATUS, 8'h04);
      bus(1'b1, `IDX_IF_CONTROL0, 8'h04);
      resync(30);
      chkrd(`IDX_STATUS, 8'h04);
      endt("modes");
      bus(1'b1, `IDX_IF_CONTROL0, 8'h14);
      bus(1'b1, `IDX_IF_CONTROL1, 8'h20);
      repeat (8) @(posedge clk);
      chkrd(`IDX_STATUS, 8'h01);
      invertPol <= 1'b1;
      repeat (60) @(posedge clk);
      chkrd(`IDX_STATUS, 8'h04);
      endt("polarity");
      bus(1'b1, `IDX_IF_CONTROL0, 8'h34);
      got0.delete();
      repeat (20) @(posedge clk);
      `CHK(got0.size() > 8, 1'b1)
      bus(1'b1, `IDX_IF_CONTROL0, 8'h14);
      repeat (4) @(posedge clk);
      got0.delete();
      repeat (20) @(posedge clk);
      `CHK(got0.size(), 0)
      endt("test samples");
      alnCnt = 0;
      push({16'h0555, 16'h0AAA}, 12);
      `CHK(alnCnt > 0, 1'b1)
      bus(1'b1, `IDX_IF_CONTROL0, 8'h16);
      alnCnt = 0;
      push({16'h0555, 16'h0AAA}, 12);
      `CHK(alnCnt, 0)
      endt("alignment chars");
      bus(1'b1, `IDX_POWER_DELAY, 8'h03);
      repeat (4) @(posedge clk);
      `CHK(lanePhyPowerDown, 2'b11)
      `CHK(laneOut0, 18'h00000)
      `CHK(laneOut1, 18'h00000)
      endt("power down");
      report_and_stop();
   end
endmodule

// ### verilog/framer_defines.svh
// offsets, field positions, reset values and link characters of the framer
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH
// ==========================================
// register indices (byte address = 4 * index)
`define IDX_FRAMES_PER_MF 10'h1C5
`define IDX_CONV_COUNT 10'h1C6
`define IDX_SAMPLES_PER_FRAME 10'h1C9
`define IDX_RESERVED_ONE 10'h1CB
`define IDX_RESERVED_TWO 10'h1CC
`define IDX_LANE0_ID 10'h1D0
`define IDX_LANE1_ID 10'h1D1
`define IDX_LANE0_CHECKSUM 10'h1D8
`define IDX_LANE1_CHECKSUM 10'h1D9
`define IDX_QUEUE_START 10'h1E0
`define IDX_SWAP 10'h1E1
`define IDX_POWER_DELAY 10'h1E2
`define IDX_IF_CONTROL0 10'h1E3
`define IDX_IF_CONTROL1 10'h1E4
`define IDX_REPEAT_COUNT 10'h1E6
`define IDX_STATUS 10'h1F0
// ==========================================
// reset values
`define RST_FRAMES_PER_MF 8'h1F
`define RST_CONV_COUNT 8'h01
`define RST_SAMPLES_PER_FRAME 8'h00
`define RST_LANE0_ID 8'h00
`define RST_LANE1_ID 8'h01
`define RST_LANE0_CHECKSUM 8'h44
`define RST_LANE1_CHECKSUM 8'h45
`define RST_IF_CONTROL0 8'h14
`define RST_ZERO 8'h00
// ==========================================
// field positions
`define POS_QUEUE_ENABLE 0
`define POS_CONV0_SWAP 4
`define POS_CONV1_SWAP 5
`define POS_LANE0_SWAP 0
`define POS_LANE1_SWAP 1
`define POS_DELAY_LO 4
`define POS_DELAY_HI 7
`define POS_TEST_SAMPLE 5
`define POS_LANE_SYNC 4
`define POS_MODE_LO 2
`define POS_MODE_HI 3
`define POS_ALIGN_OFF 1
`define POS_SYNC_INVERT 5
// ==========================================
// alignment modes and link characters
`define MODE_NORMAL 2'h1
`define MODE_CONTINUOUS 2'h3
`define CHAR_SYNC 16'h00BC
`define CHAR_MF_START 16'h001C
`define CHAR_ALIGN 16'h007C
`endif

// ### verilog/framer_pkg.sv
// types shared by the framer
package framer_pkg;
   typedef struct packed {
      logic [15:0] q;
      logic [15:0] i;
   } sample_pair_t;
   typedef struct packed {
      logic valid;
      logic ctrl;
      logic [15:0] data;
   } lane_word_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SYNC,
      ST_DELAY,
      ST_ALIGN,
      ST_DATA
   } link_state_t;
endpackage

// ### verilog/serial_link_framer_config.sv
// transmit framer with avalon register file, sample fifo and lane sequencing
//
// Summary of operation
// - frames per multiframe is field plus one
// - converter count code 1 means two converters
// - samples per frame must stay zero
// - five-bit lane identifiers, lane1 resets to one
// - per-lane checksum, resets 0x44 and 0x45
// - lane queue starts only once enabled
// - swap bits pick converter sources
// - swap bits pick physical lane sources
// - alignment starts at next multiframe after release
// - start delay postpones by multiframe periods
// - power-down bits silence each lane
// - test-sample bit sends transport test samples
// - lane sync enable bit, default on
// - mode 01 normal, 11 continuous alignment
// - alignment character insertion, one disables
// - sync request active low unless inverted
// - alignment sent repeat count plus one
`timescale 1ns/1ps
`include "framer_defines.svh"

// ==========================================
// sample fifo
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   logic [AW:0] count_nxt;
   logic push;
   logic pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("sample_fifo depth must be a power of two, at least 2");
   end

   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem_r[rdPtr_r];

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= '0;
         inReady <= 1'b0;
         outValid <= 1'b0;
      end else begin
         count_r <= count_nxt;
         inReady <= (count_nxt != (AW+1)'(DEPTH));
         outValid <= (count_nxt != '0);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wrPtr_r] <= inData;
      end
   end
endmodule

// ==========================================
// framer top
module serial_link_framer_config
   import framer_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // sample stream
   input wire logic sampleValid,
   output logic sampleReady,
   input wire sample_pair_t sampleIn,
   // link pins
   input wire logic linkSyncRequestIn,
   output lane_word_t laneOut0,
   output lane_word_t laneOut1,
   output logic [1:0] lanePhyPowerDown
);
   // ==========================================
   // register file
   logic [7:0] framesPerMf_r;
   logic [7:0] convCount_r;
   logic [7:0] samplesPerFrame_r;
   logic [7:0] reservedOne_r;
   logic [7:0] reservedTwo_r;
   logic [7:0] lane0Id_r;
   logic [7:0] lane1Id_r;
   logic [7:0] lane0Checksum_r;
   logic [7:0] lane1Checksum_r;
   logic [7:0] queueStart_r;
   logic [7:0] swap_r;
   logic [7:0] powerDelay_r;
   logic [7:0] ifControl0_r;
   logic [7:0] ifControl1_r;
   logic [7:0] repeatCount_r;
   logic [9:0] index;
   logic doWrite;
   logic [7:0] rdByte;
   link_state_t state_r;

   assign index = address[11:2];
   assign doWrite = write && !waitrequest;

   // one wait cycle, answer on the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         framesPerMf_r <= `RST_FRAMES_PER_MF;
         convCount_r <= `RST_CONV_COUNT;
         samplesPerFrame_r <= `RST_SAMPLES_PER_FRAME;
         reservedOne_r <= `RST_ZERO;
         reservedTwo_r <= `RST_ZERO;
         lane0Id_r <= `RST_LANE0_ID;
         lane1Id_r <= `RST_LANE1_ID;
         lane0Checksum_r <= `RST_LANE0_CHECKSUM;
         lane1Checksum_r <= `RST_LANE1_CHECKSUM;
         queueStart_r <= `RST_ZERO;
         swap_r <= `RST_ZERO;
         powerDelay_r <= `RST_ZERO;
         ifControl0_r <= `RST_IF_CONTROL0;
         ifControl1_r <= `RST_ZERO;
         repeatCount_r <= `RST_ZERO;
      end else if (doWrite) begin
         case (index)
            `IDX_FRAMES_PER_MF: framesPerMf_r <= writedata[7:0];
            `IDX_CONV_COUNT: convCount_r <= writedata[7:0];
            `IDX_SAMPLES_PER_FRAME: samplesPerFrame_r <= writedata[7:0];
            `IDX_RESERVED_ONE: reservedOne_r <= writedata[7:0];
            `IDX_RESERVED_TWO: reservedTwo_r <= writedata[7:0];
            `IDX_LANE0_ID: lane0Id_r <= writedata[7:0];
            `IDX_LANE1_ID: lane1Id_r <= writedata[7:0];
            `IDX_LANE0_CHECKSUM: lane0Checksum_r <= writedata[7:0];
            `IDX_LANE1_CHECKSUM: lane1Checksum_r <= writedata[7:0];
            `IDX_QUEUE_START: queueStart_r <= writedata[7:0];
            `IDX_SWAP: swap_r <= writedata[7:0];
            `IDX_POWER_DELAY: powerDelay_r <= writedata[7:0];
            `IDX_IF_CONTROL0: ifControl0_r <= writedata[7:0];
            `IDX_IF_CONTROL1: ifControl1_r <= writedata[7:0];
            `IDX_REPEAT_COUNT: repeatCount_r <= writedata[7:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      case (index)
         `IDX_FRAMES_PER_MF: rdByte = framesPerMf_r;
         `IDX_CONV_COUNT: rdByte = convCount_r;
         `IDX_SAMPLES_PER_FRAME: rdByte = samplesPerFrame_r;
         `IDX_RESERVED_ONE: rdByte = reservedOne_r;
         `IDX_RESERVED_TWO: rdByte = reservedTwo_r;
         `IDX_LANE0_ID: rdByte = lane0Id_r;
         `IDX_LANE1_ID: rdByte = lane1Id_r;
         `IDX_LANE0_CHECKSUM: rdByte = lane0Checksum_r;
         `IDX_LANE1_CHECKSUM: rdByte = lane1Checksum_r;
         `IDX_QUEUE_START: rdByte = queueStart_r;
         `IDX_SWAP: rdByte = swap_r;
         `IDX_POWER_DELAY: rdByte = powerDelay_r;
         `IDX_IF_CONTROL0: rdByte = ifControl0_r;
         `IDX_IF_CONTROL1: rdByte = ifControl1_r;
         `IDX_REPEAT_COUNT: rdByte = repeatCount_r;
         `IDX_STATUS: rdByte = {5'h00, state_r};
         default: rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (read && waitrequest) begin
         readdata <= {24'h000000, rdByte};
      end
   end

   // ==========================================
   // control fields
   logic queueEnable;
   logic [4:0] kField;
   logic [3:0] startDelay;
   logic [1:0] alignMode;
   logic testSamples;
   logic syncEnable;
   logic alignOff;

   assign queueEnable = queueStart_r[`POS_QUEUE_ENABLE];
   assign kField = framesPerMf_r[4:0];
   assign startDelay = powerDelay_r[`POS_DELAY_HI:`POS_DELAY_LO];
   assign alignMode = ifControl0_r[`POS_MODE_HI:`POS_MODE_LO];
   assign testSamples = ifControl0_r[`POS_TEST_SAMPLE];
   assign syncEnable = ifControl0_r[`POS_LANE_SYNC];
   assign alignOff = ifControl0_r[`POS_ALIGN_OFF];

   // ==========================================
   // sync request pin
   logic syncMeta_r;
   logic syncPin_r;
   logic syncRequest;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncMeta_r <= 1'b1;
         syncPin_r <= 1'b1;
      end else begin
         syncMeta_r <= linkSyncRequestIn;
         syncPin_r <= syncMeta_r;
      end
   end

   // disabled lane sync ignores the pin
   assign syncRequest = syncEnable &&
      (ifControl1_r[`POS_SYNC_INVERT] ? syncPin_r : !syncPin_r);

   // ==========================================
   // sample path
   sample_pair_t swapped;
   sample_pair_t fifoIn;
   sample_pair_t fifoOut;
   logic fifoOutValid;
   logic fifoPop;
   logic [15:0] ramp_r;

   always_comb begin
      swapped.i = swap_r[`POS_CONV0_SWAP] ? sampleIn.q : sampleIn.i;
      swapped.q = swap_r[`POS_CONV1_SWAP] ? sampleIn.i : sampleIn.q;
      fifoIn = swapped;
      if (testSamples) begin
         fifoIn.i = ramp_r;
         fifoIn.q = ramp_r;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ramp_r <= 16'h0000;
      end else if (testSamples && sampleReady) begin
         ramp_r <= ramp_r + 16'h0001;
      end
   end

   sample_fifo #(
      .WIDTH($bits(sample_pair_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .inValid(testSamples || sampleValid),
      .inReady(sampleReady),
      .inData(fifoIn),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOut)
   );

   // ==========================================
   // multiframe clock
   logic [4:0] frameCnt_r;
   logic lastFrame;

   assign lastFrame = (frameCnt_r >= kField);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frameCnt_r <= 5'h00;
      end else if (lastFrame) begin
         frameCnt_r <= 5'h00;
      end else begin
         frameCnt_r <= frameCnt_r + 5'h01;
      end
   end

   // ==========================================
   // link sequencer
   logic [3:0] delayCnt_r;
   logic [7:0] alignMf_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         delayCnt_r <= 4'h0;
         alignMf_r <= 8'h00;
      end else if (!queueEnable) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: state_r <= ST_SYNC;
            ST_SYNC: begin
               if (!syncRequest && lastFrame) begin
                  alignMf_r <= 8'h00;
                  delayCnt_r <= startDelay;
                  if (startDelay != 4'h0) begin
                     state_r <= ST_DELAY;
                  end else if (alignMode[0]) begin
                     state_r <= ST_ALIGN;
                  end else begin
                     state_r <= ST_DATA;
                  end
               end
            end
            ST_DELAY: begin
               if (syncRequest) begin
                  state_r <= ST_SYNC;
               end else if (lastFrame) begin
                  delayCnt_r <= delayCnt_r - 4'h1;
                  if (delayCnt_r == 4'h1) begin
                     state_r <= alignMode[0] ? ST_ALIGN : ST_DATA;
                  end
               end
            end
            ST_ALIGN: begin
               if (syncRequest) begin
                  state_r <= ST_SYNC;
               end else if (lastFrame) begin
                  alignMf_r <= alignMf_r + 8'h01;
                  if (alignMode == `MODE_CONTINUOUS) begin
                     alignMf_r <= 8'h00;
                  end else if (alignMf_r == repeatCount_r) begin
                     state_r <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (syncRequest) begin
                  state_r <= ST_SYNC;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // lane words
   lane_word_t frame0;
   lane_word_t frame1;
   lane_word_t phys0;
   lane_word_t phys1;
   logic [15:0] prev0_r;
   logic [15:0] prev1_r;

   assign fifoPop = (state_r == ST_DATA) && fifoOutValid;

   always_comb begin
      frame0 = '{valid: 1'b1, ctrl: 1'b1, data: `CHAR_SYNC};
      frame1 = frame0;
      case (state_r)
         ST_IDLE: begin
            frame0 = '0;
            frame1 = '0;
         end
         ST_ALIGN: begin
            if (frameCnt_r == 5'h00) begin
               frame0.data = `CHAR_MF_START;
               frame1.data = `CHAR_MF_START;
            end else if (lastFrame) begin
               frame0.data = `CHAR_ALIGN;
               frame1.data = `CHAR_ALIGN;
            end else begin
               frame0.ctrl = 1'b0;
               frame1.ctrl = 1'b0;
               frame0.data = {lane0Checksum_r, 3'h0, lane0Id_r[4:0]};
               frame1.data = {lane1Checksum_r, 3'h0, lane1Id_r[4:0]};
            end
         end
         ST_DATA: begin
            if (fifoOutValid) begin
               frame0 = '{valid: 1'b1, ctrl: 1'b0, data: fifoOut.i};
               frame1 = '{valid: 1'b1, ctrl: 1'b0, data: fifoOut.q};
               // repeated last sample becomes the alignment character
               if (lastFrame && !alignOff && fifoOut.i == prev0_r) begin
                  frame0 = '{valid: 1'b1, ctrl: 1'b1, data: `CHAR_ALIGN};
               end
               if (lastFrame && !alignOff && fifoOut.q == prev1_r) begin
                  frame1 = '{valid: 1'b1, ctrl: 1'b1, data: `CHAR_ALIGN};
               end
            end
         end
         default: ;
      endcase
      phys0 = swap_r[`POS_LANE0_SWAP] ? frame1 : frame0;
      phys1 = swap_r[`POS_LANE1_SWAP] ? frame0 : frame1;
      if (lanePhyPowerDown[0]) begin
         phys0 = '0;
      end
      if (lanePhyPowerDown[1]) begin
         phys1 = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev0_r <= 16'h0000;
         prev1_r <= 16'h0000;
      end else if (fifoPop) begin
         prev0_r <= fifoOut.i;
         prev1_r <= fifoOut.q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         laneOut0 <= '0;
         laneOut1 <= '0;
         lanePhyPowerDown <= 2'h0;
      end else begin
         laneOut0 <= phys0;
         laneOut1 <= phys1;
         lanePhyPowerDown <= powerDelay_r[1:0];
      end
   end
endmodule
